/* rtl/clfm_regs.svh */
`ifndef CLFM_REGS_SVH
`define CLFM_REGS_SVH
`define CLFM_CTRL_OFS    8'h00
`define CLFM_STAT_OFS    8'h04
`define CLFM_CFG_OFS     8'h08
`define CLFM_CTRL_IBURST 0
`define CLFM_CTRL_DBURST 1
`define CLFM_CTRL_RST    2'h0
`define CLFM_ILINE_WORDS 4'h8
`define CLFM_CACHE_MIN   512
`define CLFM_CACHE_MAX   65536
`define CLFM_TCM_MAX     4
`define CLFM_CFG_NTCI    4
`define CLFM_CFG_NTCD    7
`define CLFM_CFG_DWORDS  10
`endif

/* rtl/clfm_pkg.sv */
package clfm_pkg;
  typedef enum logic [1:0] {I_IDLE, I_CMD, I_DATA} clfm_ist_e;
  typedef enum logic [1:0] {D_IDLE, D_CMD, D_DATA, D_WB} clfm_dst_e;
endpackage

/* rtl/clfm_top.sv */
`timescale 1ns/10ps
`include "clfm_regs.svh"
module clfm_top #(
  parameter int IC_SIZE    = 4096,
  parameter int DC_SIZE    = 2048,
  parameter int DC_LINE    = 32,
  parameter bit IC_BURST   = 1'b1,
  parameter bit DC_BURST   = 1'b1,
  parameter int NUM_TCIM   = 1,
  parameter int NUM_TCDM   = 0,
  parameter bit VICTIM_RAM = 1'b0,
  parameter bit RSTREQ_EN  = 1'b1
) (
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic [31:0]      HRDATA,
  input  wire logic        IMISS_VALID,
  input  wire logic [31:0] IMISS_ADDR,
  output logic             IMISS_READY,
  output logic             IFILL_VALID,
  output logic [2:0]       IFILL_IDX,
  output logic [31:0]      IFILL_DATA,
  output logic             IFILL_DONE,
  output logic             I_READ,
  output logic [31:0]      I_ADDR,
  output logic [3:0]       I_BURSTCOUNT,
  input  wire logic        I_WAITREQUEST,
  input  wire logic [31:0] I_RDATA,
  input  wire logic        I_RDATAVALID,
  input  wire logic        DMISS_VALID,
  input  wire logic [31:0] DMISS_ADDR,
  output logic             DMISS_READY,
  output logic             DFILL_VALID,
  output logic [2:0]       DFILL_IDX,
  output logic [31:0]      DFILL_DATA,
  output logic             DFILL_DONE,
  input  wire logic        VICT_WE,
  input  wire logic [2:0]  VICT_WIDX,
  input  wire logic [31:0] VICT_WDATA,
  input  wire logic        VICT_START,
  input  wire logic [31:0] VICT_ADDR,
  output logic             VICT_READY,
  output logic             D_READ,
  output logic             D_WRITE,
  output logic [31:0]      D_ADDR,
  output logic [31:0]      D_WDATA,
  output logic [3:0]       D_BURSTCOUNT,
  input  wire logic        D_WAITREQUEST,
  input  wire logic [31:0] D_RDATA,
  input  wire logic        D_RDATAVALID,
  output logic [3:0]       TCIM_EN,
  output logic [3:0]       TCDM_EN,
  input  wire logic        CPU_RESETREQUEST,
  output logic             CPU_RESETTAKEN
);
  // out-of-range sizes are taken as none
  localparam bit IC_ON = (IC_SIZE >= `CLFM_CACHE_MIN) && (IC_SIZE <= `CLFM_CACHE_MAX);
  localparam bit DC_ON = (DC_SIZE >= `CLFM_CACHE_MIN) && (DC_SIZE <= `CLFM_CACHE_MAX);
  localparam bit DM_ON = DC_ON || (NUM_TCDM == 0);
  localparam int DLN   = (DC_LINE == 32) ? 32 : (DC_LINE == 16) ? 16 : 4;
  localparam logic [3:0] DWORDS = 4'(DLN / 4);
  localparam logic [2:0] DLAST  = 3'(DLN / 4 - 1);
  localparam bit DB_OK = DC_BURST && (DLN > 4);

  function automatic logic [2:0] wrapidx(input logic [2:0] b, input logic [2:0] c);
    wrapidx = b + c; // 3-bit sum wraps inside the 32-byte line
  endfunction

  logic [1:0]  ctrl_r;
  logic        wr_pend_r;
  logic [7:0]  wa_r;
  logic [31:0] hrdata_r;
  logic        cpu_rst_r;
  clfm_pkg::clfm_ist_e i_st_r;
  clfm_pkg::clfm_dst_e d_st_r;
  logic [26:0] i_base_r;
  logic [2:0]  i_crit_r, i_cnt_r;
  logic        i_burst_r;
  logic [29:0] d_wa_r;
  logic [2:0]  d_cnt_r;
  logic        d_burst_r;
  logic [31:0] vbuf [0:7];
  logic        ifv_r, ifd_r, dfv_r, dfd_r;
  logic [2:0]  ifi_r, dfi_r;
  logic [31:0] ifdat_r, dfdat_r;

  // bus slave: zero wait states, always OKAY
  wire         ahb_acc  = HSEL && HTRANS[1] && HREADY;
  wire [31:0]  stat_w   = {28'h0, cpu_rst_r, d_st_r == clfm_pkg::D_WB,
                           d_st_r != clfm_pkg::D_IDLE && d_st_r != clfm_pkg::D_WB,
                           i_st_r != clfm_pkg::I_IDLE};
  wire [31:0]  cfg_w    = {18'h0, DWORDS, 3'(NUM_TCDM), 3'(NUM_TCIM), DM_ON, IC_ON,
                           DC_ON, IC_ON};
  wire [31:0]  rd_mux   = (HADDR[7:0] == `CLFM_CTRL_OFS) ? {30'h0, ctrl_r} :
                          (HADDR[7:0] == `CLFM_STAT_OFS) ? stat_w :
                          (HADDR[7:0] == `CLFM_CFG_OFS)  ? cfg_w : 32'h0;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = hrdata_r;

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      wr_pend_r <= 1'b0;
      wa_r      <= 8'h00;
      hrdata_r  <= 32'h0;
      ctrl_r    <= `CLFM_CTRL_RST;
    end else begin
      wr_pend_r <= ahb_acc && HWRITE && (HADDR[31:8] == 24'h0);
      wa_r      <= HADDR[7:0];
      if (ahb_acc && !HWRITE) hrdata_r <= (HADDR[31:8] == 24'h0) ? rd_mux : 32'h0;
      if (wr_pend_r && wa_r == `CLFM_CTRL_OFS) ctrl_r <= HWDATA[1:0];
    end
  end

  // processor-only reset; clears on release so a held request keeps it in reset
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) cpu_rst_r <= 1'b0;
    else cpu_rst_r <= RSTREQ_EN && CPU_RESETREQUEST;
  end
  assign CPU_RESETTAKEN = cpu_rst_r;

  genvar g;
  generate
    for (g = 0; g < `CLFM_TCM_MAX; g++) begin : g_tcm
      assign TCIM_EN[g] = (g < NUM_TCIM) || (g == 0);
      assign TCDM_EN[g] = (g < NUM_TCDM);
    end
  endgenerate

  // instruction fill engine
  wire [2:0] i_word = wrapidx(i_crit_r, i_cnt_r);
  assign IMISS_READY  = IC_ON && i_st_r == clfm_pkg::I_IDLE && !cpu_rst_r;
  assign I_READ       = IC_ON && i_st_r == clfm_pkg::I_CMD;
  assign I_ADDR       = {i_base_r, i_word, 2'b00};
  assign I_BURSTCOUNT = i_burst_r ? `CLFM_ILINE_WORDS : 4'h1;

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      i_st_r    <= clfm_pkg::I_IDLE;
      i_base_r  <= 27'h0;
      i_crit_r  <= 3'h0;
      i_cnt_r   <= 3'h0;
      i_burst_r <= 1'b0;
    end else if (cpu_rst_r) begin
      i_st_r <= clfm_pkg::I_IDLE;
    end else begin
      case (i_st_r)
        clfm_pkg::I_IDLE: if (IMISS_VALID && IMISS_READY) begin
          i_base_r  <= IMISS_ADDR[31:5];
          i_crit_r  <= IMISS_ADDR[4:2];
          i_cnt_r   <= 3'h0;
          i_burst_r <= IC_BURST && ctrl_r[`CLFM_CTRL_IBURST];
          i_st_r    <= clfm_pkg::I_CMD;
        end
        clfm_pkg::I_CMD: if (!I_WAITREQUEST) i_st_r <= clfm_pkg::I_DATA;
        clfm_pkg::I_DATA: if (I_RDATAVALID) begin
          i_cnt_r <= i_cnt_r + 3'h1;
          if (i_cnt_r == 3'h7) i_st_r <= clfm_pkg::I_IDLE;
          else if (!i_burst_r) i_st_r <= clfm_pkg::I_CMD;
        end
        default: i_st_r <= clfm_pkg::I_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      ifv_r   <= 1'b0;
      ifd_r   <= 1'b0;
      ifi_r   <= 3'h0;
      ifdat_r <= 32'h0;
    end else begin
      ifv_r <= i_st_r == clfm_pkg::I_DATA && I_RDATAVALID && !cpu_rst_r;
      ifd_r <= i_st_r == clfm_pkg::I_DATA && I_RDATAVALID && !cpu_rst_r && i_cnt_r == 3'h7;
      if (I_RDATAVALID) begin
        ifi_r   <= i_word;
        ifdat_r <= I_RDATA;
      end
    end
  end
  assign IFILL_VALID = ifv_r;
  assign IFILL_DONE  = ifd_r;
  assign IFILL_IDX   = ifi_r;
  assign IFILL_DATA  = ifdat_r;

  // data fill and victim write-back share the data master; write-back wins
  wire [29:0] d_mask = ~{27'h0, DLAST};
  wire        d_idle = d_st_r == clfm_pkg::D_IDLE && !cpu_rst_r;
  assign VICT_READY   = DC_ON && DM_ON && d_idle;
  assign DMISS_READY  = DC_ON && DM_ON && d_idle && !VICT_START;
  assign D_READ       = DM_ON && d_st_r == clfm_pkg::D_CMD;
  assign D_WRITE      = DM_ON && d_st_r == clfm_pkg::D_WB;
  assign D_ADDR       = {d_wa_r | {27'h0, d_cnt_r}, 2'b00};
  assign D_WDATA      = vbuf[d_cnt_r];
  assign D_BURSTCOUNT = (d_burst_r && D_READ) ? DWORDS : 4'h1;

  // register or RAM style gives the same behaviour; VICTIM_RAM is not used by any logic here
  always_ff @(posedge CLOCK) begin
    if (VICT_WE) vbuf[VICT_WIDX] <= VICT_WDATA;
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      d_st_r    <= clfm_pkg::D_IDLE;
      d_wa_r    <= 30'h0;
      d_cnt_r   <= 3'h0;
      d_burst_r <= 1'b0;
    end else if (cpu_rst_r) begin
      d_st_r <= clfm_pkg::D_IDLE;
    end else begin
      case (d_st_r)
        clfm_pkg::D_IDLE: if (VICT_START && VICT_READY) begin
          d_wa_r  <= VICT_ADDR[31:2] & d_mask;
          d_cnt_r <= 3'h0;
          d_st_r  <= clfm_pkg::D_WB;
        end else if (DMISS_VALID && DMISS_READY) begin
          d_wa_r    <= DMISS_ADDR[31:2] & d_mask;
          d_cnt_r   <= 3'h0;
          d_burst_r <= DB_OK && ctrl_r[`CLFM_CTRL_DBURST];
          d_st_r    <= clfm_pkg::D_CMD;
        end
        clfm_pkg::D_CMD: if (!D_WAITREQUEST) d_st_r <= clfm_pkg::D_DATA;
        clfm_pkg::D_DATA: if (D_RDATAVALID) begin
          d_cnt_r <= d_cnt_r + 3'h1;
          if (d_cnt_r == DLAST) d_st_r <= clfm_pkg::D_IDLE;
          else if (!d_burst_r) d_st_r <= clfm_pkg::D_CMD;
        end
        clfm_pkg::D_WB: if (!D_WAITREQUEST) begin
          d_cnt_r <= d_cnt_r + 3'h1;
          if (d_cnt_r == DLAST) d_st_r <= clfm_pkg::D_IDLE;
        end
        default: d_st_r <= clfm_pkg::D_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      dfv_r   <= 1'b0;
      dfd_r   <= 1'b0;
      dfi_r   <= 3'h0;
      dfdat_r <= 32'h0;
    end else begin
      dfv_r <= d_st_r == clfm_pkg::D_DATA && D_RDATAVALID && !cpu_rst_r;
      dfd_r <= d_st_r == clfm_pkg::D_DATA && D_RDATAVALID && !cpu_rst_r && d_cnt_r == DLAST;
      if (D_RDATAVALID) begin
        dfi_r   <= d_cnt_r;
        dfdat_r <= D_RDATA;
      end
    end
  end
  assign DFILL_VALID = dfv_r;
  assign DFILL_DONE  = dfd_r;
  assign DFILL_IDX   = dfi_r;
  assign DFILL_DATA  = dfdat_r;

  // checking helpers: order of delivered instruction words
  logic       ifirst_r;
  logic [2:0] ilast_r, ibeg_r;
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      ifirst_r <= 1'b1;
      ilast_r  <= 3'h0;
      ibeg_r   <= 3'h0;
    end else if (IFILL_VALID) begin
      ifirst_r <= IFILL_DONE;
      ilast_r  <= IFILL_IDX;
      if (ifirst_r) ibeg_r <= IFILL_IDX;
    end else if (cpu_rst_r) begin
      ifirst_r <= 1'b1;
    end
  end

  sequence s_imiss_acc;
    IMISS_VALID && IMISS_READY;
  endsequence
  sequence s_dmiss_acc;
    DMISS_VALID && DMISS_READY && !VICT_START;
  endsequence

  a_icrit_first: assert property (@(posedge CLOCK) disable iff (RESET)
    s_imiss_acc |=> I_READ && I_ADDR == ($past(IMISS_ADDR) & 32'hffff_fffc))
    else $error("fill did not start at requested word");
  a_iwrap_step: assert property (@(posedge CLOCK) disable iff (RESET || cpu_rst_r)
    IFILL_VALID && !ifirst_r |-> IFILL_IDX == ilast_r + 3'h1)
    else $error("instruction fill word out of wrap order");
  a_iline_end: assert property (@(posedge CLOCK) disable iff (RESET || cpu_rst_r)
    IFILL_DONE |-> IFILL_VALID && IFILL_IDX == ibeg_r - 3'h1 && !ifirst_r)
    else $error("instruction fill did not cover the line");
  a_iburst_len: assert property (@(posedge CLOCK) disable iff (RESET)
    I_READ |-> I_BURSTCOUNT == (i_burst_r ? 4'h8 : 4'h1) && (!i_burst_r || i_cnt_r == 3'h0))
    else $error("instruction burst command malformed");
  a_dalign_start: assert property (@(posedge CLOCK) disable iff (RESET)
    s_dmiss_acc |=> D_READ && (D_ADDR[4:2] & DLAST) == 3'h0)
    else $error("data fill not line aligned");
  a_dburst_len: assert property (@(posedge CLOCK) disable iff (RESET)
    D_READ |-> D_BURSTCOUNT == ((d_burst_r && DLN > 4) ? DWORDS : 4'h1))
    else $error("data burst length wrong");
  a_port_omit: assert property (@(posedge CLOCK) disable iff (RESET)
    (!DM_ON |-> !D_READ && !D_WRITE) and (!IC_ON |-> !I_READ && !IMISS_READY))
    else $error("omitted master port active");
  a_wb_hold: assert property (@(posedge CLOCK) disable iff (RESET || cpu_rst_r)
    D_WRITE && D_WAITREQUEST |=> D_WRITE && $stable(D_ADDR))
    else $error("write-back dropped while stalled");
  a_rst_taken: assert property (@(posedge CLOCK) disable iff (RESET)
    RSTREQ_EN && CPU_RESETREQUEST ##1 CPU_RESETREQUEST |-> CPU_RESETTAKEN ##1
    (!IMISS_READY && !VICT_READY))
    else $error("reset acknowledge or hold missing");
  a_rst_release: assert property (@(posedge CLOCK) disable iff (RESET)
    !CPU_RESETREQUEST |=> !CPU_RESETTAKEN)
    else $error("acknowledge stayed after release");
endmodule

/* verif/clfm_slave_model.sv */
`timescale 1ns/10ps
module clfm_slave_model #(
  parameter bit WRAP = 1'b0
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        slow,
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic [31:0] addr,
  input  wire logic [3:0]  bcount,
  input  wire logic [31:0] wdata,
  output logic             waitreq,
  output logic [31:0]      rdata,
  output logic             rvalid
);
  logic [31:0] log_a[$];
  logic [31:0] log_d[$];
  logic [31:0] base_r;
  logic [3:0]  left_r;
  logic [2:0]  beat_r;
  logic        stall_r;
  wire  [31:0] beat_addr = WRAP ? {base_r[31:5], 5'(base_r[4:0] + {beat_r, 2'h0})}
                                : base_r + {27'h0, beat_r, 2'h0};
  // slow mode stalls every other cycle so held commands get exercised
  assign waitreq = slow & stall_r;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      stall_r <= 1'b0;
      left_r  <= 4'h0;
      beat_r  <= 3'h0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
    end else begin
      stall_r <= ~stall_r;
      rvalid  <= (left_r != 4'h0);
      // idle data lines toggle, a stale beat never looks fresh
      rdata   <= (left_r != 4'h0) ? beat_addr ^ 32'h5a5a0000 : ~rdata;
      if (left_r != 4'h0) begin
        beat_r <= beat_r + 3'h1;
        left_r <= left_r - 4'h1;
      end
      if ((rd | wr) && !waitreq) begin
        log_a.push_back(addr);
        log_d.push_back(wr ? wdata : {28'h0, bcount});
        if (rd) begin
          base_r <= addr;
          left_r <= bcount;
          beat_r <= 3'h0;
        end
      end
    end
  end
endmodule

/* verif/cache_line_fill_master_tb.sv */
`timescale 1ns/10ps
`include "clfm_regs.svh"
module cache_line_fill_master_tb;
  logic        CLOCK, HREADY, HREADYOUT, HRESP, IMISS_READY, IFILL_VALID, IFILL_DONE, I_READ;
  logic        I_WAITREQUEST, I_RDATAVALID, DMISS_READY, DFILL_VALID, DFILL_DONE, VICT_READY;
  logic        D_READ, D_WRITE, D_WAITREQUEST, D_RDATAVALID, CPU_RESETTAKEN;
  logic        RESET = 1'b1, HSEL = 1'b0, HWRITE = 1'b0, IMISS_VALID = 1'b0, DMISS_VALID = 1'b0;
  logic        VICT_WE = 1'b0, VICT_START = 1'b0, CPU_RESETREQUEST = 1'b0, slow = 1'b0;
  logic [1:0]  HTRANS = 2'h0;
  logic [2:0]  HSIZE = 3'h2, VICT_WIDX = 3'h0, IFILL_IDX, DFILL_IDX;
  logic [3:0]  I_BURSTCOUNT, D_BURSTCOUNT, TCIM_EN, TCDM_EN;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, IMISS_ADDR = 32'h0, DMISS_ADDR = 32'h0;
  logic [31:0] VICT_WDATA = 32'h0, VICT_ADDR = 32'h0, HRDATA, IFILL_DATA, I_ADDR, I_RDATA;
  logic [31:0] DFILL_DATA, D_ADDR, D_WDATA, D_RDATA, q;
  logic [35:0] fqi[$], fqd[$];
  int          miscompares = 0, n_checks = 0, cyc = 0;
  assign HREADY = HREADYOUT;
  clfm_top u_dut (
    .CLOCK, .RESET, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY, .HREADYOUT,
    .HRESP, .HRDATA, .IMISS_VALID, .IMISS_ADDR, .IMISS_READY, .IFILL_VALID, .IFILL_IDX,
    .IFILL_DATA, .IFILL_DONE, .I_READ, .I_ADDR, .I_BURSTCOUNT, .I_WAITREQUEST, .I_RDATA,
    .I_RDATAVALID, .DMISS_VALID, .DMISS_ADDR, .DMISS_READY, .DFILL_VALID, .DFILL_IDX,
    .DFILL_DATA, .DFILL_DONE, .VICT_WE, .VICT_WIDX, .VICT_WDATA, .VICT_START, .VICT_ADDR,
    .VICT_READY, .D_READ, .D_WRITE, .D_ADDR, .D_WDATA, .D_BURSTCOUNT, .D_WAITREQUEST,
    .D_RDATA, .D_RDATAVALID, .TCIM_EN, .TCDM_EN, .CPU_RESETREQUEST, .CPU_RESETTAKEN);
  // one memory per master port
  clfm_slave_model #(.WRAP(1'b1)) u_imem (.clock(CLOCK), .reset(RESET), .slow(slow),
    .rd(I_READ), .wr(1'b0), .addr(I_ADDR), .bcount(I_BURSTCOUNT), .wdata(32'h0),
    .waitreq(I_WAITREQUEST), .rdata(I_RDATA), .rvalid(I_RDATAVALID));
  clfm_slave_model #(.WRAP(1'b0)) u_dmem (.clock(CLOCK), .reset(RESET), .slow(slow),
    .rd(D_READ), .wr(D_WRITE), .addr(D_ADDR), .bcount(D_BURSTCOUNT), .wdata(D_WDATA),
    .waitreq(D_WAITREQUEST), .rdata(D_RDATA), .rvalid(D_RDATAVALID));
  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (IFILL_VALID === 1'b1) fqi.push_back({IFILL_DONE, IFILL_IDX, IFILL_DATA});
    if (DFILL_VALID === 1'b1) fqd.push_back({DFILL_DONE, DFILL_IDX, DFILL_DATA});
    if (cyc == 6000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR  <= {24'h0, a};
    do @(posedge CLOCK); while (HREADY !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLOCK); while (HREADY !== 1'b1);
    q = HRDATA;
  endtask
  task automatic fill(input bit d, input logic [31:0] a, input bit bst);
    int          n0;
    logic [2:0]  w;
    logic [35:0] got;
    n0 = d ? u_dmem.log_a.size() : u_imem.log_a.size();
    if (d) fqd.delete();
    else fqi.delete();
    if (d) begin
      DMISS_VALID <= 1'b1;
      DMISS_ADDR  <= a;
    end else begin
      IMISS_VALID <= 1'b1;
      IMISS_ADDR  <= a;
    end
    do @(negedge CLOCK); while ((d ? DMISS_READY : IMISS_READY) !== 1'b1);
    @(posedge CLOCK);
    IMISS_VALID <= 1'b0;
    DMISS_VALID <= 1'b0;
    do @(posedge CLOCK); while ((d ? fqd.size() : fqi.size()) < 8);
    chk((d ? u_dmem.log_a.size() : u_imem.log_a.size()) - n0, bst ? 1 : 8);
    for (int k = 0; k < 8; k++) begin
      w = d ? 3'(k) : a[4:2] + 3'(k);
      got = d ? fqd[k] : fqi[k];
      chk(got, {k == 7, w, {a[31:5], w, 2'h0} ^ 32'h5a5a0000});
      if (k < (bst ? 1 : 8)) begin
        chk(d ? u_dmem.log_a[n0 + k] : u_imem.log_a[n0 + k], {a[31:5], w, 2'h0});
        chk(d ? u_dmem.log_d[n0 + k] : u_imem.log_d[n0 + k], bst ? 8 : 1);
      end
    end
  endtask
  task automatic wback(input logic [31:0] a);
    int n0;
    n0 = u_dmem.log_a.size();
    for (int k = 0; k < 8; k++) begin
      VICT_WE    <= 1'b1;
      VICT_WIDX  <= 3'(k);
      VICT_WDATA <= 32'hb000_0000 + k;
      @(posedge CLOCK);
    end
    VICT_WE    <= 1'b0;
    VICT_START <= 1'b1;
    VICT_ADDR  <= a;
    do @(negedge CLOCK); while (VICT_READY !== 1'b1);
    @(posedge CLOCK);
    VICT_START <= 1'b0;
    do @(posedge CLOCK); while (u_dmem.log_a.size() < n0 + 8);
    for (int k = 0; k < 8; k++) begin
      chk(u_dmem.log_a[n0 + k], {a[31:5], 5'h0} + 4 * k);
      chk(u_dmem.log_d[n0 + k], 32'hb000_0000 + k);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge CLOCK);
    RESET <= 1'b0;
    ahb(1'b0, `CLFM_CTRL_OFS, 32'h0);
    chk(q, 32'h0);
    ahb(1'b0, `CLFM_CFG_OFS, 32'h0);
    chk(q, 32'h0000_201f);
    chk({TCIM_EN, TCDM_EN, HRESP}, 9'h020);
    ahb(1'b1, 8'h40, 32'hffff_ffff);
    ahb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    $display("test registers done");
    fill(1'b0, 32'h1000_0008, 1'b0);
    fill(1'b0, 32'h1000_0100, 1'b0);
    slow <= 1'b1;
    fill(1'b1, 32'h2000_0048, 1'b0);
    $display("test single fills done");
    ahb(1'b1, `CLFM_CTRL_OFS, 32'h3);
    ahb(1'b0, `CLFM_CTRL_OFS, 32'h0);
    chk(q, 32'h3);
    fill(1'b0, 32'h1000_021c, 1'b1);
    fill(1'b1, 32'h2000_0088, 1'b1);
    $display("test burst fills done");
    wback(32'h3000_0054);
    $display("test write-back done");
    // request held past the acknowledge and through a status read, then released
    CPU_RESETREQUEST <= 1'b1;
    @(posedge CLOCK);
    @(negedge CLOCK);
    chk(CPU_RESETTAKEN, 1'b1);
    chk({IMISS_READY, DMISS_READY, VICT_READY}, 3'h0);
    @(posedge CLOCK);
    ahb(1'b0, `CLFM_STAT_OFS, 32'h0);
    chk(q, 32'h8);
    chk({IMISS_READY, DMISS_READY, VICT_READY}, 3'h0);
    CPU_RESETREQUEST <= 1'b0;
    @(posedge CLOCK);
    @(negedge CLOCK);
    chk({CPU_RESETTAKEN, IMISS_READY, DMISS_READY, VICT_READY}, 4'h7);
    $display("test processor reset done");
    wrap_up();
  end
endmodule
